/* design/rescue_operation_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module rescue_operation_sequencer #(
    parameter int unsigned TICK_CYCLES = rescue_pkg::UNIT_CYCLES,
    parameter logic [15:0] UV_LEVEL    = 16'h0073,
    parameter logic [15:0] UPS_GAIN    = 16'h0001
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        rescue_input_function,
    input  wire logic        up_cmd,
    input  wire logic        down_cmd,
    input  wire logic [15:0] bus_voltage,
    input  wire logic [15:0] load_meas,
    input  wire logic        zero_speed,
    output logic      [15:0] speed_ref,
    output logic             dir_up,
    output logic             run,
    output logic      [15:0] torque_limit,
    output logic             light_direction_output,
    output logic             search_done_output,
    output logic             control_supply_undervoltage_fault,
    output logic             deterioration,
    output logic             irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= {down_cmd, up_cmd, rescue_input_function};
            sync_q <= meta_q;
        end
    end
    wire rescue_s = sync_q[0];
    wire up_s     = sync_q[1];
    wire down_s   = sync_q[2];
    wire cmd_s    = up_s | down_s;

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_q, rescue_speed_ref, search_speed_ref, search_run_time;
    logic [15:0] rescue_torque_limit, normal_torque_limits, ups_power_value;
    logic [15:0] reference_bus_voltage, deterioration_level;
    localparam int IRQ_W_L = rescue_pkg::IRQ_W - 1;
    logic [IRQ_W_L:0] irq_st_q, irq_msk_q;

    wire wr_irqs = wr && addr == rescue_pkg::IRQST_ADDR;
    wire search_enable          = ctrl_q[rescue_pkg::CTRL_SEARCH_EN];
    wire ups_speed_limit_select = ctrl_q[rescue_pkg::CTRL_UPS_LIM];
    wire [1:0] backup_supply_type = ctrl_q[rescue_pkg::CTRL_TYPE_LO +: 2];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q                <= rescue_pkg::CTRL_RST;
            rescue_speed_ref      <= rescue_pkg::RSPEED_RST;
            search_speed_ref      <= rescue_pkg::SSPEED_RST;
            search_run_time       <= rescue_pkg::STIME_RST;
            rescue_torque_limit   <= rescue_pkg::TORQUE_RST;
            normal_torque_limits  <= rescue_pkg::TORQUE_RST;
            ups_power_value       <= rescue_pkg::UPSPWR_RST;
            reference_bus_voltage <= rescue_pkg::REFBUS_RST;
            deterioration_level   <= rescue_pkg::DETLVL_RST;
            irq_msk_q             <= '0;
        end else if (wr) begin
            unique case (addr)
                rescue_pkg::CTRL_ADDR:    ctrl_q                <= wdata;
                rescue_pkg::RSPEED_ADDR:  rescue_speed_ref      <= wdata;
                rescue_pkg::SSPEED_ADDR:  search_speed_ref      <= wdata;
                rescue_pkg::STIME_ADDR:   search_run_time       <= wdata;
                rescue_pkg::RTORQUE_ADDR: rescue_torque_limit   <= wdata;
                rescue_pkg::NTORQUE_ADDR: normal_torque_limits  <= wdata;
                rescue_pkg::UPSPWR_ADDR:  ups_power_value       <= wdata;
                rescue_pkg::REFBUS_ADDR:  reference_bus_voltage <= wdata;
                rescue_pkg::DETLVL_ADDR:  deterioration_level   <= wdata;
                rescue_pkg::IRQMSK_ADDR:  irq_msk_q             <= wdata[IRQ_W_L:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Speed limit from UPS power
    // ------------------------------------------------------------
    wire [31:0] ups_prod = ups_power_value * UPS_GAIN;
    wire ups_lim_on = ups_speed_limit_select && backup_supply_type != rescue_pkg::TYPE_BATTERY;
    wire [15:0] ups_cap = (ups_prod[31:16] != 16'h0) ? 16'hFFFF : ups_prod[15:0];
    wire [15:0] rescue_lim = (ups_lim_on && ups_cap < rescue_speed_ref) ? ups_cap
                                                                          : rescue_speed_ref;

    // ------------------------------------------------------------
    // Direction search sequencer
    // ------------------------------------------------------------
    rescue_pkg::seq_state_t state_q, state_d;
    logic        done_q, light_up_q, rescue_q;
    logic [31:0] acc_up_q, acc_dn_q;
    logic        tmr_start, tmr_exp;

    // The last down sample arrives on the deciding edge; adding it here gives both runs
    // the same number of samples, so equal loads really compare equal.
    wire [31:0] acc_dn_now = acc_dn_q + {16'h0, load_meas};
    wire up_lighter = acc_up_q < acc_dn_now;
    wire start_search = search_enable && !done_q && cmd_s;

    always_comb begin
        state_d   = state_q;
        tmr_start = 1'b0;
        unique case (state_q)
            rescue_pkg::ST_IDLE: begin
                if (rescue_s && start_search) begin
                    state_d   = rescue_pkg::ST_SRCH_UP;
                    tmr_start = 1'b1;
                end else if (rescue_s && cmd_s) begin
                    state_d = rescue_pkg::ST_TRAVEL;
                end
            end
            rescue_pkg::ST_SRCH_UP: begin
                if (tmr_exp) begin
                    state_d   = rescue_pkg::ST_SRCH_DN;
                    tmr_start = 1'b1;
                end
            end
            rescue_pkg::ST_SRCH_DN: begin
                if (tmr_exp) begin
                    state_d = up_lighter ? rescue_pkg::ST_STOP
                                         : rescue_pkg::ST_TRAVEL;
                end
            end
            rescue_pkg::ST_STOP: begin
                if (zero_speed) begin
                    state_d = rescue_pkg::ST_TRAVEL;
                end
            end
            rescue_pkg::ST_TRAVEL: begin
                if (!cmd_s) begin
                    state_d = rescue_pkg::ST_IDLE;
                end
            end
        endcase
        if (!rescue_s) begin
            state_d   = rescue_pkg::ST_IDLE;
            tmr_start = 1'b0;
        end
    end

    search_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .mclk    (mclk),
        .rstn    (rstn),
        .start   (tmr_start),
        .units   (search_run_time),
        .expired (tmr_exp)
    );

    wire in_up = state_q == rescue_pkg::ST_SRCH_UP;
    wire in_dn = state_q == rescue_pkg::ST_SRCH_DN;
    wire search_end = in_dn && tmr_exp;
    wire [31:0] load_ext = {16'h0, load_meas};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= rescue_pkg::ST_IDLE;
            done_q     <= 1'b0;
            light_up_q <= 1'b0;
            rescue_q   <= 1'b0;
            acc_up_q   <= 32'h0;
            acc_dn_q   <= 32'h0;
        end else begin
            state_q  <= state_d;
            rescue_q <= rescue_s;
            if (!rescue_s) begin
                done_q     <= 1'b0;
                light_up_q <= 1'b0;
            end else if (search_end) begin
                done_q     <= 1'b1;
                light_up_q <= up_lighter;
            end
            if (tmr_start && state_q == rescue_pkg::ST_IDLE) begin
                acc_up_q <= 32'h0;
                acc_dn_q <= 32'h0;
            end else if (in_up) begin
                acc_up_q <= acc_up_q + load_ext;
            end else if (in_dn) begin
                acc_dn_q <= acc_dn_q + load_ext;
            end
        end
    end

    // ------------------------------------------------------------
    // Supply supervision
    // ------------------------------------------------------------
    wire misconfig = search_enable && (search_run_time == 16'h0 || search_speed_ref == 16'h0);
    wire uv_now = rescue_s && (bus_voltage < UV_LEVEL || misconfig);
    wire [16:0] det_sum = {1'b0, bus_voltage} + {1'b0, deterioration_level};
    wire det_now = rescue_s && run && det_sum < {1'b0, reference_bus_voltage};

    // ------------------------------------------------------------
    // Drive outputs, all registered
    // ------------------------------------------------------------
    wire searching = in_up || in_dn;
    wire travel    = state_q == rescue_pkg::ST_TRAVEL;
    wire [15:0] speed_d = searching ? search_speed_ref : travel ? rescue_lim : 16'h0;
    wire dir_d = in_up || (travel && (done_q ? light_up_q : up_s));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            speed_ref                         <= 16'h0;
            dir_up                            <= 1'b0;
            run                               <= 1'b0;
            torque_limit                      <= rescue_pkg::TORQUE_RST;
            light_direction_output            <= 1'b0;
            search_done_output                <= 1'b0;
            control_supply_undervoltage_fault <= 1'b0;
            deterioration                     <= 1'b0;
        end else begin
            speed_ref <= speed_d;
            dir_up    <= dir_d;
            run       <= searching || travel;
            torque_limit <= rescue_s ? rescue_torque_limit : normal_torque_limits;
            light_direction_output <= light_up_q;
            search_done_output     <= done_q;
            if (!rescue_s) begin
                control_supply_undervoltage_fault <= 1'b0;
                deterioration                     <= 1'b0;
            end else begin
                if (uv_now) control_supply_undervoltage_fault <= 1'b1;
                if (det_now) deterioration <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts and read back
    // ------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle.
    wire [IRQ_W_L:0] irq_ev = {rescue_s && !rescue_q,
                               uv_now && !control_supply_undervoltage_fault,
                               det_now && !deterioration, search_end};
    wire [IRQ_W_L:0] irq_clr = wr_irqs ? wdata[IRQ_W_L:0] : '0;
    wire [15:0] status_w = {11'h0, control_supply_undervoltage_fault, deterioration,
                            light_up_q, done_q, rescue_s};
    logic [15:0] rd_mux;
    always_comb begin
        unique case (addr)
            rescue_pkg::CTRL_ADDR:    rd_mux = ctrl_q;
            rescue_pkg::RSPEED_ADDR:  rd_mux = rescue_speed_ref;
            rescue_pkg::SSPEED_ADDR:  rd_mux = search_speed_ref;
            rescue_pkg::STIME_ADDR:   rd_mux = search_run_time;
            rescue_pkg::RTORQUE_ADDR: rd_mux = rescue_torque_limit;
            rescue_pkg::NTORQUE_ADDR: rd_mux = normal_torque_limits;
            rescue_pkg::UPSPWR_ADDR:  rd_mux = ups_power_value;
            rescue_pkg::REFBUS_ADDR:  rd_mux = reference_bus_voltage;
            rescue_pkg::DETLVL_ADDR:  rd_mux = deterioration_level;
            rescue_pkg::STATUS_ADDR:  rd_mux = status_w;
            rescue_pkg::IRQST_ADDR:   rd_mux = {12'h0, irq_st_q};
            rescue_pkg::IRQMSK_ADDR:  rd_mux = {12'h0, irq_msk_q};
            default:                  rd_mux = 16'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_st_q <= '0;
            irq      <= 1'b0;
            rdata    <= 16'h0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
            irq      <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_msk_q);
            rdata    <= rd ? rd_mux : 16'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    rescue_speed_a: assert property (@(posedge mclk) disable iff (!rstn)
        travel |=> speed_ref == $past(rescue_lim) && run)
        else $error("rescue travel speed wrong");
    torque_sel_a: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> torque_limit == ($past(rescue_s) ? $past(rescue_torque_limit)
                                                  : $past(normal_torque_limits)))
        else $error("torque limit not selected by mode");
    search_start_a: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == rescue_pkg::ST_IDLE && rescue_s && start_search
        |=> state_q == rescue_pkg::ST_SRCH_UP ##1 dir_up && speed_ref == search_speed_ref)
        else $error("search did not start upward");
    search_order_a: assert property (@(posedge mclk) disable iff (!rstn)
        in_up && tmr_exp && rescue_s |=> in_dn ##1 !dir_up)
        else $error("search order wrong");
    search_speed_a: assert property (@(posedge mclk) disable iff (!rstn)
        searching |=> speed_ref == $past(search_speed_ref))
        else $error("search speed not used");
    up_stop_a: assert property (@(posedge mclk) disable iff (!rstn)
        search_end && rescue_s && up_lighter
        |=> state_q == rescue_pkg::ST_STOP ##1 light_direction_output && search_done_output
            && speed_ref == 16'h0)
        else $error("up lighter handling wrong");
    down_go_a: assert property (@(posedge mclk) disable iff (!rstn)
        search_end && rescue_s && !up_lighter && cmd_s
        |=> travel ##1 !light_direction_output && search_done_output && !dir_up)
        else $error("down lighter handling wrong");
    uv_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        uv_now |=> control_supply_undervoltage_fault)
        else $error("undervoltage fault not raised");
    deter_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        det_now |=> deterioration)
        else $error("deterioration not flagged");
endmodule
`default_nettype wire

/* inc/rescue_pkg.sv */
// Function
// - Rescue input runs car at rescue speed.
// - Rescue torque limit in rescue, normal after.
// - Search enabled runs at each rescue start.
// - Search up then down, go lighter way.
// - Search runs use search speed reference.
// - Up lighter: stop, go up, both outputs close.
// - Down lighter: go on, only done closes.
// - Supply type, UPS power, UPS speed limit.
// - Flag deterioration against reference bus voltage.
// - Undervoltage fault on low supply or misconfiguration.
package rescue_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR     = 4'h0;
    localparam logic [3:0] RSPEED_ADDR   = 4'h1;
    localparam logic [3:0] SSPEED_ADDR   = 4'h2;
    localparam logic [3:0] STIME_ADDR    = 4'h3;
    localparam logic [3:0] RTORQUE_ADDR  = 4'h4;
    localparam logic [3:0] NTORQUE_ADDR  = 4'h5;
    localparam logic [3:0] UPSPWR_ADDR   = 4'h6;
    localparam logic [3:0] REFBUS_ADDR   = 4'h7;
    localparam logic [3:0] DETLVL_ADDR   = 4'h8;
    localparam logic [3:0] STATUS_ADDR   = 4'h9;
    localparam logic [3:0] IRQST_ADDR    = 4'hA;
    localparam logic [3:0] IRQMSK_ADDR   = 4'hB;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_SEARCH_EN = 0;
    localparam int CTRL_UPS_LIM   = 1;
    localparam int CTRL_TYPE_LO   = 2;
    localparam int ST_RESCUE      = 0;
    localparam int ST_DONE        = 1;
    localparam int ST_LIGHT_UP    = 2;
    localparam int ST_DETER       = 3;
    localparam int ST_UV          = 4;
    localparam int IRQ_DONE       = 0;
    localparam int IRQ_DETER      = 1;
    localparam int IRQ_UV         = 2;
    localparam int IRQ_ENTRY      = 3;
    localparam int IRQ_W          = 4;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] RSPEED_RST  = 16'h0000;
    localparam logic [15:0] SSPEED_RST  = 16'h0000;
    localparam logic [15:0] STIME_RST   = 16'h0000;
    localparam logic [15:0] TORQUE_RST  = 16'h0000;
    localparam logic [15:0] UPSPWR_RST  = 16'h0000;
    localparam logic [15:0] REFBUS_RST  = 16'h0000;
    localparam logic [15:0] DETLVL_RST  = 16'h0000;
    localparam logic [1:0]  TYPE_BATTERY = 2'h0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SEARCH_UNIT_NS = 1000000;
    localparam int unsigned UNIT_CYCLES = SEARCH_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SRCH_UP, ST_SRCH_DN, ST_STOP, ST_TRAVEL
    } seq_state_t;
endpackage

/* design/search_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module search_timer #(
    parameter int unsigned TICK_CYCLES = rescue_pkg::UNIT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [15:0] units,
    output logic             expired
);
    // ------------------------------------------------------------
    // Prescaler to whole time units, then a unit count down.
    // ------------------------------------------------------------
    logic [31:0] pre_q;
    logic [15:0] left_q;
    logic        busy_q;
    wire         tick = (pre_q == TICK_CYCLES - 1);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pre_q   <= 32'h0;
            left_q  <= 16'h0;
            busy_q  <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            pre_q   <= 32'h0;
            left_q  <= units;
            busy_q  <= (units != 16'h0);
            expired <= (units == 16'h0);
        end else if (busy_q) begin
            pre_q <= tick ? 32'h0 : pre_q + 32'h1;
            if (tick) begin
                left_q  <= left_q - 16'h1;
                busy_q  <= (left_q != 16'h1);
                expired <= (left_q == 16'h1);
            end
        end else begin
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verification/rescue_controller_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Elevator controller: contactor and command sequencing
// ------------------------------------------------------------
module rescue_controller_model (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic run_req,
    input  wire logic go_up,
    input  wire logic zero_speed,
    output logic      rescue_input_function,
    output logic      up_cmd,
    output logic      down_cmd,
    output logic      mains_closed,
    output logic      backup_closed
);
    localparam logic [3:0] SETTLE_CYCLES = 4'h4;
    logic [2:0] step_q;
    logic [3:0] settle_q;
    logic       adv;

    // Only one contactor or pin moves per step, so no two of them change in the same cycle.
    assign adv = (step_q == 3'h0) ? run_req :
                 (step_q == 3'h4) ? !run_req :
                 (step_q == 3'h5) ? (zero_speed && settle_q == SETTLE_CYCLES) : 1'b1;
    assign mains_closed          = (step_q == 3'h0);
    assign rescue_input_function = (step_q >= 3'h2) && (step_q <= 3'h6);
    assign backup_closed         = (step_q >= 3'h3) && (step_q <= 3'h5);
    assign up_cmd                = (step_q == 3'h4) && go_up;
    assign down_cmd              = (step_q == 3'h4) && !go_up;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            step_q   <= 3'h0;
            settle_q <= 4'h0;
        end else begin
            if (adv) begin
                step_q <= step_q + 3'h1;
            end
            // Backup stays on until zero_speed and a settle count of SETTLE_CYCLES cycles before it is removed, so settings
            // written under the rescue supply are not cut off mid-store.
            if (step_q != 3'h5) begin
                settle_q <= 4'h0;
            end else if (settle_q != SETTLE_CYCLES) begin
                settle_q <= settle_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [15:0] CFG [9] = '{16'h0000, 16'h0100, 16'h0020, 16'h0002, 16'h0050,
                                        16'h0090, 16'h0040, 16'h00C8, 16'h000A};
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] bus_voltage = 16'h0100;
    logic [15:0] load_meas = 16'h0010;
    logic        zero_speed = 1'b1;
    logic        run_req = 1'b0;
    logic        go_up = 1'b1;
    logic        heavy_down = 1'b0;
    logic        watch = 1'b0;
    logic        dropped = 1'b0;
    logic [15:0] rdata, speed_ref, torque_limit, rv;
    logic        rescue_in, up_c, down_c, mains_c, backup_c;
    logic        dir_up, run, light, done, uv, deter, irq;
    int          errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          nw;

    always #50 mclk = ~mclk;

    // The motor is taken as stopped one cycle after the drive stops it.
    always @(posedge mclk) begin
        zero_speed <= ~run;
        load_meas  <= (heavy_down && !dir_up) ? 16'h0030 : 16'h0010;
        if (watch && run !== 1'b1) begin
            dropped <= 1'b1;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            conclude();
        end
    end

    rescue_controller_model ctl (.mclk(mclk), .rstn(rstn), .run_req(run_req), .go_up(go_up),
        .zero_speed(zero_speed), .rescue_input_function(rescue_in), .up_cmd(up_c),
        .down_cmd(down_c), .mains_closed(mains_c), .backup_closed(backup_c));

    rescue_operation_sequencer #(.TICK_CYCLES(4)) DUT (.mclk(mclk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rescue_input_function(rescue_in),
        .up_cmd(up_c), .down_cmd(down_c), .bus_voltage(bus_voltage), .load_meas(load_meas),
        .zero_speed(zero_speed), .speed_ref(speed_ref), .dir_up(dir_up), .run(run),
        .torque_limit(torque_limit), .light_direction_output(light),
        .search_done_output(done), .control_supply_undervoltage_fault(uv),
        .deterioration(deter), .irq(irq));

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp_word(input string w, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cmp_bit(input string w, input logic e, input logic g);
        cmp_word(w, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return run;
            1: return dir_up;
            2: return done;
            3: return uv;
            default: return mains_c;
        endcase
    endfunction

    task automatic wt(input int s, input logic v);
        for (nw = 0; nw < 300 && pick(s) !== v; nw++) begin
            cyc_wait(1);
        end
        cmp_bit("wait", v, pick(s));
    endtask

    task automatic go_rescue(input logic up);
        @(posedge mclk);
        go_up   <= up;
        run_req <= 1'b1;
        wt(0, 1'b1);
    endtask

    task automatic end_rescue();
        @(posedge mclk);
        run_req <= 1'b0;
        wt(4, 1'b1);
        cyc_wait(4);
    endtask

    task automatic s_regs();
        wr_reg(rescue_pkg::STATUS_ADDR, 16'hFFFF);
        wr_reg(4'hC, 16'hFFFF);
        for (int i = 0; i < 16; i++) begin
            rd_reg(i[3:0], rv);
            cmp_word("reset value", 16'h0000, rv);
        end
        for (int i = 0; i < 9; i++) begin
            wr_reg(i[3:0], CFG[i]);
            rd_reg(i[3:0], rv);
            cmp_word("readback", CFG[i], rv);
        end
    endtask

    task automatic s_plain();
        wr_reg(rescue_pkg::IRQMSK_ADDR, 16'h0008);
        go_rescue(1'b1);
        cmp_word("rescue speed", CFG[1], speed_ref);
        cmp_bit("direction", 1'b1, dir_up);
        cmp_word("rescue torque", CFG[4], torque_limit);
        cmp_bit("entry irq", 1'b1, irq);
        wr_reg(rescue_pkg::IRQST_ADDR, 16'h0008);
        cyc_wait(3);
        cmp_bit("irq cleared", 1'b0, irq);
        bus_voltage <= 16'h0080;
        cyc_wait(6);
        cmp_bit("deterioration", 1'b1, deter);
        cmp_bit("undervoltage", 1'b0, uv);
        bus_voltage <= 16'h0100;
        end_rescue();
        cmp_word("normal torque", CFG[5], torque_limit);
    endtask

    task automatic s_search(input logic up_light);
        heavy_down <= up_light;
        wr_reg(rescue_pkg::CTRL_ADDR, 16'h0001);
        go_rescue(!up_light);
        cmp_word("search speed up", CFG[2], speed_ref);
        cmp_bit("search starts up", 1'b1, dir_up);
        watch = !up_light;
        wt(1, 1'b0);
        cmp_bit("up run length", 1'b1, nw >= 7 && nw <= 9);
        cmp_word("search speed down", CFG[2], speed_ref);
        if (up_light) begin
            wt(0, 1'b0);
            cmp_word("stopped speed", 16'h0000, speed_ref);
            wt(0, 1'b1);
        end
        wt(2, 1'b1);
        watch = 1'b0;
        cmp_word("travel speed", CFG[1], speed_ref);
        cmp_bit("travel direction", up_light, dir_up);
        cmp_bit("light output", up_light, light);
        cmp_bit("no stop", 1'b0, dropped);
        heavy_down <= 1'b0;
        end_rescue();
    endtask

    task automatic s_limits();
        wr_reg(rescue_pkg::CTRL_ADDR, 16'h0006);
        go_rescue(1'b1);
        cmp_word("ups capped speed", CFG[6], speed_ref);
        end_rescue();
        wr_reg(rescue_pkg::CTRL_ADDR, 16'h0001);
        wr_reg(rescue_pkg::STIME_ADDR, 16'h0000);
        @(posedge mclk);
        run_req <= 1'b1;
        wt(3, 1'b1);
        end_rescue();
        cmp_bit("fault cleared", 1'b0, uv);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        s_regs();
        s_plain();
        s_search(1'b0);
        s_search(1'b1);
        s_limits();
        conclude();
    end
endmodule
`default_nettype wire
